/* File: shared/buzzer_pkg.sv */
// constants, register map and timing for the buzzer tone driver
package buzzer_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int TONE_HI_HZ = 4000;
  localparam int TONE_LO_HZ = 2000;
  localparam int GATE_BASE_HZ = 32;
  localparam int TICK_CYCLES_DEF = CLK_HZ / (2 * TONE_HI_HZ);
  localparam int SUB_DIV_DEF = (2 * TONE_HI_HZ) / GATE_BASE_HZ;
  localparam int TONE_LO_TICKS = (2 * TONE_HI_HZ) / TONE_LO_HZ;

  localparam int IDX_CTRL = 'h0a;
  localparam int IDX_FREQ = 'h0b;
  localparam int IDX_STAT = 'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'(IDX_CTRL * 4);
  localparam logic [7:0] ADDR_FREQ = 8'(IDX_FREQ * 4);
  localparam logic [7:0] ADDR_STAT = 8'(IDX_STAT * 4);

  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] FREQ_RESET = 4'he;
  localparam int CTRL_POL_BIT = 3;
  localparam int CTRL_EN_BIT = 2;
  localparam int CTRL_MODE_HI = 1;
  localparam int CTRL_MODE_LO = 0;
  localparam int FREQ_SEL_BIT = 0;

  localparam logic [1:0] MODE_PATTERN1 = 2'h0;
  localparam logic [1:0] MODE_PATTERN2 = 2'h1;
  localparam logic [1:0] MODE_BURST = 2'h2;
  localparam logic [1:0] MODE_CONT = 2'h3;

  localparam int GATE_CNT_W = 5;
  localparam int GATE_16HZ_BIT = 0;
  localparam int GATE_8HZ_BIT = 1;
  localparam int GATE_1HZ_BIT = 4;

  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_FREQ = 2'h2;
  localparam logic [1:0] SEL_STAT = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: src/buzzer_tone_driver.sv */
// buzzer tone driver with axi4-lite register slave
//
// How it works
// - tone reaches pin only while enable set
// - frequency select picks 4 kHz or 2 kHz
// - reset clears frequency select, 4 kHz default
// - two mode bits choose one of four modes
// - polarity bit sets idle level and inversion
// - tone is square wave, equal halves
// - pattern one gates tone with 8 Hz
// - pattern two gates with 8 Hz and not-1 Hz
// - burst starts on enable rise, ends 16 Hz fall
// - continuous mode drives tone while enabled
// - reset clears enable bit
// - reset clears mode bits, pattern one
// - reset clears polarity bit, idle low
`timescale 1ns/1ps
module buzzer_tone_driver
  import buzzer_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int SUB_DIV = SUB_DIV_DEF,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tone_out_pin
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int SUB_W = $clog2(SUB_DIV + 1);

  if (TICK_CYCLES < 1 || SUB_DIV < 2 || ADDR_W < 8) begin : g_check
    $error("buzzer_tone_driver: unsupported parameter values");
  end

  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = addr[7:0];
    if ((addr >> 8) != '0) begin
      return SEL_NONE;
    end
    if (a == ADDR_CTRL) begin
      return SEL_CTRL;
    end
    if (a == ADDR_FREQ) begin
      return SEL_FREQ;
    end
    if (a == ADDR_STAT) begin
      return SEL_STAT;
    end
    return SEL_NONE;
  endfunction

  // time base dividers
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [SUB_W-1:0] sub_cnt_reg;
  logic [1:0] tone_cnt_reg;
  logic [GATE_CNT_W-1:0] gate_cnt_reg;
  wire tick_pulse = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
  wire sub_pulse = tick_pulse && (sub_cnt_reg == SUB_W'(SUB_DIV - 1));
  wire [TICK_W-1:0] tick_cnt_next = tick_pulse ? '0 : tick_cnt_reg + TICK_W'(1);
  wire [SUB_W-1:0] sub_cnt_next = sub_pulse ? '0 : (tick_pulse ? sub_cnt_reg + SUB_W'(1) : sub_cnt_reg);
  wire [1:0] tone_cnt_next = tick_pulse ? tone_cnt_reg + 2'h1 : tone_cnt_reg;
  wire [GATE_CNT_W-1:0] gate_cnt_next = sub_pulse ? gate_cnt_reg + GATE_CNT_W'(1) : gate_cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= '0;
      sub_cnt_reg <= '0;
      tone_cnt_reg <= 2'h0;
      gate_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      sub_cnt_reg <= sub_cnt_next;
      tone_cnt_reg <= tone_cnt_next;
      gate_cnt_reg <= gate_cnt_next;
    end
  end

  wire tb_16hz = gate_cnt_reg[GATE_16HZ_BIT];
  wire tb_8hz = gate_cnt_reg[GATE_8HZ_BIT];
  wire tb_1hz = gate_cnt_reg[GATE_1HZ_BIT];

  // axi4-lite write path
  logic aw_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic w_hold_reg;
  logic [3:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  wire aw_take = s_axi_awvalid && !aw_hold_reg;
  wire w_take = s_axi_wvalid && !w_hold_reg;
  wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire [1:0] wsel = reg_sel(awaddr_reg);
  wire wr_lane = do_write && wstrb0_reg;
  wire [1:0] bresp_next = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      w_hold_reg <= 1'b0;
      wdata_reg <= 4'h0;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[3:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= bresp_next;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // control and frequency registers
  logic [3:0] ctrl_reg;
  logic freq_reg;
  wire [3:0] ctrl_next = (wr_lane && wsel == SEL_CTRL) ? wdata_reg : ctrl_reg;
  wire freq_next = (wr_lane && wsel == SEL_FREQ) ? wdata_reg[FREQ_SEL_BIT] : freq_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      freq_reg <= FREQ_RESET[FREQ_SEL_BIT];
    end else begin
      ctrl_reg <= ctrl_next;
      freq_reg <= freq_next;
    end
  end

  wire output_polarity_sel = ctrl_reg[CTRL_POL_BIT];
  wire tone_enable = ctrl_reg[CTRL_EN_BIT];
  wire tone_mode_hi = ctrl_reg[CTRL_MODE_HI];
  wire tone_mode_lo = ctrl_reg[CTRL_MODE_LO];
  wire [1:0] tone_mode = {tone_mode_hi, tone_mode_lo};
  wire tone_freq_sel = freq_reg;

  // single burst tracking
  logic en_d_reg;
  logic tb16_d_reg;
  logic burst_reg;
  wire en_rise = tone_enable && !en_d_reg;
  wire tb16_fall = tb16_d_reg && !tb_16hz;
  // start on rise, stop at 16 Hz fall
  wire burst_next = (en_rise && tone_mode == MODE_BURST) ? 1'b1 :
                    (tb16_fall || !tone_enable || tone_mode != MODE_BURST) ? 1'b0 : burst_reg;

  // select 4 kHz or 2 kHz bit
  wire tone_wave = tone_freq_sel ? tone_cnt_reg[1] : tone_cnt_reg[0];

  wire mode_gate = (tone_mode == MODE_PATTERN1) ? tb_8hz :
                   (tone_mode == MODE_PATTERN2) ? (tb_8hz && !tb_1hz) :
                   (tone_mode == MODE_BURST) ? burst_reg : 1'b1;
  wire tone_active = tone_enable && mode_gate;
  wire pin_next = (tone_active && tone_wave) ^ output_polarity_sel;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_d_reg <= 1'b0;
      tb16_d_reg <= 1'b0;
      burst_reg <= 1'b0;
      tone_out_pin <= 1'b0;
    end else begin
      en_d_reg <= tone_enable;
      tb16_d_reg <= tb_16hz;
      burst_reg <= burst_next;
      tone_out_pin <= pin_next;
    end
  end

  // axi4-lite read path
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  wire ar_take = s_axi_arvalid && !rvalid_reg;
  wire [1:0] rsel = reg_sel(s_axi_araddr);
  wire [3:0] rd_word = (rsel == SEL_CTRL) ? ctrl_reg :
                       (rsel == SEL_FREQ) ? {FREQ_RESET[3:1], freq_reg} :
                       (rsel == SEL_STAT) ? {2'h0, burst_reg, tone_active} : 4'h0;
  wire [1:0] rresp_next = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {28'h0, rd_word};
      rresp_reg <= rresp_next;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  property p_reset_clears;
    @(posedge aclk) !aresetn |=> (ctrl_reg == 4'h0 && freq_reg == 1'b0);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("registers not cleared by reset");

  property p_idle_when_off;
    @(posedge aclk) disable iff (!aresetn)
      (!tone_enable && $stable(output_polarity_sel)) |=> (tone_out_pin == $past(output_polarity_sel));
  endproperty
  a_idle_when_off: assert property (p_idle_when_off) else $error("pin not idle while disabled");

  property p_toggle_on_tick;
    @(posedge aclk) disable iff (!aresetn)
      (tone_mode == MODE_CONT && tone_enable && $stable(ctrl_reg) && $stable(freq_reg))
      ##1 $changed(tone_out_pin) |-> $past(tick_pulse, 2);
  endproperty
  a_toggle_on_tick: assert property (p_toggle_on_tick) else $error("tone edge off the tick");

  property p_low_freq;
    @(posedge aclk) disable iff (!aresetn)
      (tone_freq_sel && $stable(freq_reg) && tone_cnt_reg[1] == $past(tone_cnt_reg[1]) && $stable(ctrl_reg)
       && tone_mode == MODE_CONT) |=> $stable(tone_out_pin);
  endproperty
  a_low_freq: assert property (p_low_freq) else $error("2 kHz tone toggled early");

  property p_pattern1_gap;
    @(posedge aclk) disable iff (!aresetn)
      (tone_mode == MODE_PATTERN1 && !tb_8hz) |=> (tone_out_pin == $past(output_polarity_sel));
  endproperty
  a_pattern1_gap: assert property (p_pattern1_gap) else $error("tone outside 8 Hz window");

  property p_pattern2_gap;
    @(posedge aclk) disable iff (!aresetn)
      (tone_mode == MODE_PATTERN2 && tb_1hz) |=> (tone_out_pin == $past(output_polarity_sel));
  endproperty
  a_pattern2_gap: assert property (p_pattern2_gap) else $error("tone during 1 Hz high phase");

  property p_burst_start;
    @(posedge aclk) disable iff (!aresetn)
      (en_rise && tone_mode == MODE_BURST) |=> burst_reg;
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst did not start");

  property p_burst_stop;
    @(posedge aclk) disable iff (!aresetn)
      (burst_reg && tb16_fall && !en_rise) |=> !burst_reg ##1 (tone_out_pin == output_polarity_sel);
  endproperty
  a_burst_stop: assert property (p_burst_stop) else $error("burst did not stop at 16 Hz fall");

  property p_continuous;
    @(posedge aclk) disable iff (!aresetn)
      (tone_mode == MODE_CONT && tone_enable) |=> (tone_out_pin == ($past(tone_wave) ^ $past(output_polarity_sel)));
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous tone interrupted");

  property p_polarity;
    @(posedge aclk) disable iff (!aresetn)
      (tone_active && !tone_wave && output_polarity_sel) |=> tone_out_pin;
  endproperty
  a_polarity: assert property (p_polarity) else $error("inverted tone level wrong");
endmodule

/* File: tb/buzzer_load.sv */
// model of the external transistor stage driven by the buzzer pin
`timescale 1ns/1ps
module buzzer_load (
  input wire logic aclk,
  input wire logic drive_pin,
  input wire logic invert,
  input wire logic clr,
  output logic [15:0] on_count,
  output logic [15:0] edge_count
);
  logic last_pin;
  logic conduct;
  assign conduct = drive_pin ^ invert;
  always_ff @(posedge aclk) begin
    last_pin <= drive_pin;
    if (clr) begin
      on_count <= 16'h0000;
      edge_count <= 16'h0000;
    end else begin
      on_count <= on_count + 16'(conduct);
      edge_count <= edge_count + 16'(drive_pin != last_pin);
    end
  end
endmodule

/* File: tb/test_buzzer_tone_driver.sv */
// self-checking bench for the buzzer tone driver
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module test_buzzer_tone_driver;
  import buzzer_pkg::*;
  localparam int TICK = 4;
  localparam int SUB = 4;
  localparam int WIN = 1024;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pin, invert, clr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] on_count, edge_count;
  int err_total, total_checks;

  buzzer_tone_driver #(.TICK_CYCLES(TICK), .SUB_DIV(SUB), .ADDR_W(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tone_out_pin(pin)
  );
  buzzer_load i_load (
    .aclk(aclk), .drive_pin(pin), .invert(invert), .clr(clr), .on_count(on_count), .edge_count(edge_count)
  );

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic timed_out();
    err_total++;
    $display("unexpected at %0t: bus timeout", $time);
    print_verdict();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) timed_out();
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) timed_out();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic measure(input int n);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic t_reset();
    rd_reg(ADDR_CTRL, rd, rs);
    `CHK(pin, 1'b0)
    `CHK(rs, RESP_OKAY)
    `CHK(rd, 32'(CTRL_RESET))
    `CHK(rd[1:0], MODE_PATTERN1)
    rd_reg(ADDR_FREQ, rd, rs);
    `CHK(rd, 32'(FREQ_RESET))
    rd_reg(8'h40, rd, rs);
    `CHK(rs, RESP_SLVERR)
    wr(8'h44, 32'h7, rs);
    `CHK(rs, RESP_SLVERR)
    rd_reg(ADDR_CTRL, rd, rs);
    `CHK(rd, 32'(CTRL_RESET))
  endtask

  task automatic t_modes();
    logic [3:0] ctl [6] = '{4'h4, 4'h5, 4'h7, 4'h3, 4'hc, 4'h8};
    logic inv [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    int exp_on [6] = '{WIN / 4, WIN / 8, WIN / 2, 0, WIN / 4, 0};
    for (int i = 0; i < 6; i++) begin
      invert <= inv[i];
      wr(ADDR_CTRL, 32'(ctl[i]), rs);
      rd_reg(ADDR_CTRL, rd, rs);
      `CHK(rd, 32'(ctl[i]))
      measure(WIN);
      `CHK(on_count, 16'(exp_on[i]))
    end
    `CHK(pin, 1'b1)
  endtask

  task automatic t_freq();
    invert <= 1'b0;
    wr(ADDR_CTRL, 32'h7, rs);
    rd_reg(ADDR_STAT, rd, rs);
    `CHK(rd, 32'h1)
    measure(64);
    `CHK(edge_count, 16'(64 / TICK))
    `CHK(on_count, 16'd32)
    wr(ADDR_FREQ, 32'h1, rs);
    rd_reg(ADDR_FREQ, rd, rs);
    `CHK(rd[FREQ_SEL_BIT], 1'b1)
    measure(64);
    `CHK(edge_count, 16'(64 / (2 * TICK)))
    `CHK(on_count, 16'd32)
    wr(ADDR_FREQ, 32'h0, rs);
  endtask

  task automatic t_burst();
    int sum;
    sum = 0;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 32'h2, rs);
      repeat (8 * k) @(posedge aclk);
      wr(ADDR_CTRL, 32'h6, rs);
      measure(40);
      sum += on_count;
      `CHK(on_count <= 16'(TICK * SUB + 1), 1'b1)
      measure(256);
      `CHK(on_count, 16'd0)
    end
    `CHK(sum > 0, 1'b1)
  endtask

  // mid-run reset must clear both registers and idle the pin
  task automatic t_rereset();
    wr(ADDR_CTRL, 32'hf, rs);
    wr(ADDR_FREQ, 32'h1, rs);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    `CHK(pin, 1'b0)
    rd_reg(ADDR_CTRL, rd, rs);
    `CHK(rd, 32'(CTRL_RESET))
    rd_reg(ADDR_FREQ, rd, rs);
    `CHK(rd, 32'(FREQ_RESET))
  endtask

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    invert = 1'b0;
    clr = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_modes();
    t_freq();
    t_burst();
    t_rereset();
    print_verdict();
  end
endmodule
